// ---- transmitter_overload_sequencer.sv ----
// Notes on behaviour
// - Filament-on sets filament and blower latches, warm-up, gate input, blower relays.
// - Air flow with filament latch lights air lamp, energizes contactor and magnet.
// - Filament-off clears filament latch, drops contactor and magnet relay at once.
// - Blower and heat exchanger run on five minutes after filament-off.
// - No turn-on while any logic board is missing.
// - Beam-on sets beam latch, lights auto lamp, enables first beam input.
// - Five minutes after filament-on, warm-up completes and its lamp lights.
// - Beam enable needs latch, warm-up, interlocks, no cutoff, aux contact, magnet relay.
// - Beam enable assertion triggers the 1.5 s beam-interrupt monostable.
// - Five separate overload inputs across the two input boards.
// - Overload rising edge sets memory and indicator, pulses counter and monostable.
// - Each overload interrupts beam 1.5 s then returns unless count is three.
// - Three-stage thermometer counter; each error sets the next unset stage.
// - Each error restarts one-minute auto-clear; expiry clears latch and counter.
// - Three overloads within one minute give no automatic beam return.
// - One-shot lamp lit while stage two set and three not; dark at one.
// - One-shot button sets stage two directly and lights its lamp.
// - Stage three cuts beam, darkens one-shot lamp, flashes fault, holds auto-clear.
// - Overload held over 0.5 s sets stage three directly.
// - Fault clear empties counter and auto-clear latch; beam may return.
// - Overload memory clear empties all memories and indicators.
`timescale 1ns/1ps

module transmitter_overload_sequencer
  import tos_pkg::*;
#(
  parameter int unsigned OVL_N = OVL_COUNT,
  parameter int unsigned TICK_DIVIDE = TICK_DIV,
  parameter int unsigned RUNON_COUNT = RUNON_TICKS,
  parameter int unsigned WARMUP_COUNT = WARMUP_TICKS,
  parameter int unsigned CLEAR_COUNT = CLEAR_TICKS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Operator pushbuttons
  input wire tos_buttons_type buttons,
  // Contacts and sensors
  input wire logic air_flow_normal,
  input wire logic boards_present,
  input wire logic interlocks_closed,
  input wire logic filament_aux_closed,
  input wire logic magnet_current_relay,
  input wire logic [OVL_N-1:0] overload_in,
  // Relay drivers
  output tos_relays_type relays,
  output logic beam_enable,
  // Lamps and indicators
  output tos_lamps_type lamps,
  output logic [OVL_N-1:0] overload_memory,
  output logic [2:0] fault_stages
);

  // Synchronised copies; inputs are already synchronous so one stage suffices
  tos_buttons_type btn_q;
  tos_buttons_type btn_prev;
  logic [OVL_N-1:0] ovl_q;
  logic [OVL_N-1:0] ovl_prev;
  logic air_q;
  logic boards_q;
  logic interlock_q;
  logic aux_q;
  logic magnet_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      btn_q <= '0;
      btn_prev <= '0;
      ovl_q <= '0;
      ovl_prev <= '0;
      air_q <= 1'b0;
      boards_q <= 1'b0;
      interlock_q <= 1'b0;
      aux_q <= 1'b0;
      magnet_q <= 1'b0;
    end else begin
      btn_q <= buttons;
      btn_prev <= btn_q;
      ovl_q <= overload_in;
      ovl_prev <= ovl_q;
      air_q <= air_flow_normal;
      boards_q <= boards_present;
      interlock_q <= interlocks_closed;
      aux_q <= filament_aux_closed;
      magnet_q <= magnet_current_relay;
    end
  end

  tos_buttons_type press;
  assign press = btn_q & ~btn_prev;

  logic [OVL_N-1:0] ovl_rise;
  assign ovl_rise = ovl_q & ~ovl_prev;

  // Millisecond tick divider
  logic [$clog2(TICK_DIVIDE)-1:0] div_count;
  logic tick;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_count <= '0;
      tick <= 1'b0;
    end else if (div_count == ($clog2(TICK_DIVIDE))'(TICK_DIVIDE - 1)) begin
      div_count <= '0;
      tick <= 1'b1;
    end else begin
      div_count <= div_count + 1'b1;
      tick <= 1'b0;
    end
  end

  // Filament and blower sequencing
  logic filament_latch;
  logic blower_latch;
  logic [TIMER_W-1:0] runon_count;
  logic turn_on;
  assign turn_on = press.filament_on_button && boards_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      filament_latch <= 1'b0;
      blower_latch <= 1'b0;
      runon_count <= '0;
    end else if (press.filament_off_button) begin
      filament_latch <= 1'b0;
      runon_count <= '0;
    end else if (turn_on) begin
      filament_latch <= 1'b1;
      blower_latch <= 1'b1;
      runon_count <= '0;
    end else if (!filament_latch && blower_latch && tick) begin
      if (runon_count == TIMER_W'(RUNON_COUNT - 1)) begin
        blower_latch <= 1'b0;
        runon_count <= '0;
      end else begin
        runon_count <= runon_count + 1'b1;
      end
    end
  end

  // Warm-up delay latch
  logic warmup_latch;
  logic warmup_done;
  logic [TIMER_W-1:0] warmup_count;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      warmup_latch <= 1'b0;
      warmup_done <= 1'b0;
      warmup_count <= '0;
    end else if (press.filament_off_button) begin
      warmup_latch <= 1'b0;
      warmup_done <= 1'b0;
      warmup_count <= '0;
    end else if (turn_on && !warmup_latch) begin
      warmup_latch <= 1'b1;
      warmup_count <= '0;
    end else if (warmup_latch && !warmup_done && tick) begin
      if (warmup_count == TIMER_W'(WARMUP_COUNT - 1)) begin
        warmup_done <= 1'b1;
      end else begin
        warmup_count <= warmup_count + 1'b1;
      end
    end
  end

  // Beam latch; filament-off drops it too since the beam cannot run without filament
  logic beam_latch;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      beam_latch <= 1'b0;
    end else if (press.filament_off_button) begin
      beam_latch <= 1'b0;
    end else if (press.beam_on_button && boards_q) begin
      beam_latch <= 1'b1;
    end
  end

  // Overload memories and stuck-input timers, one per input
  logic [OVL_N-1:0] stuck_hit;

  generate
    for (genvar i = 0; i < OVL_N; i++) begin : g_ovl
      logic [TIMER_W-1:0] high_count;
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          overload_memory[i] <= 1'b0;
        end else if (ovl_rise[i]) begin
          overload_memory[i] <= 1'b1;
        end else if (press.overload_memory_clear) begin
          overload_memory[i] <= 1'b0;
        end
      end
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          high_count <= '0;
          stuck_hit[i] <= 1'b0;
        end else if (!ovl_q[i]) begin
          high_count <= '0;
          stuck_hit[i] <= 1'b0;
        end else if (tick && high_count != TIMER_W'(STUCK_TICKS)) begin
          high_count <= high_count + 1'b1;
          stuck_hit[i] <= (high_count == TIMER_W'(STUCK_TICKS - 1));
        end
        // Hit stays up while the input is held: a fault clear cannot outlast a held overload
      end
    end
  endgenerate

  logic error_pulse;
  assign error_pulse = |ovl_rise;

  // Three-stage fault counter with auto-clear latch
  logic [TIMER_W-1:0] clear_count;
  logic autoclear_latch;
  logic autoclear_expire;
  assign autoclear_expire = autoclear_latch && tick
                            && clear_count == TIMER_W'(CLEAR_COUNT - 1);

  logic [2:0] counted_stages;
  assign counted_stages = {fault_stages[1:0], 1'b1} | fault_stages;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fault_stages <= '0;
    end else if (error_pulse || |stuck_hit || press.one_shot_trip_button) begin
      // New faults win over a clear in the same cycle; coincident sources all land
      fault_stages <= (error_pulse ? counted_stages : fault_stages)
                      | {|stuck_hit, press.one_shot_trip_button, 1'b0};
    end else if (press.fault_clear_button || autoclear_expire) begin
      fault_stages <= '0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      autoclear_latch <= 1'b0;
      clear_count <= '0;
    end else if (fault_stages[2] || press.fault_clear_button) begin
      autoclear_latch <= 1'b0;
      clear_count <= '0;
    end else if (error_pulse) begin
      autoclear_latch <= 1'b1;
      clear_count <= '0;
    end else if (autoclear_latch && tick) begin
      if (autoclear_expire) begin
        autoclear_latch <= 1'b0;
        clear_count <= '0;
      end else begin
        clear_count <= clear_count + 1'b1;
      end
    end
  end

  logic beam_cutoff;
  assign beam_cutoff = fault_stages[2];

  // Beam gate and interrupt monostable
  logic next_beam_enable;
  assign next_beam_enable = beam_latch && warmup_done && interlock_q && !beam_cutoff
                            && aux_q && magnet_q;

  logic [TIMER_W-1:0] mono_count;
  logic interrupt_q;
  logic mono_trigger;
  assign mono_trigger = (next_beam_enable && !beam_enable) || error_pulse;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      beam_enable <= 1'b0;
    end else begin
      beam_enable <= next_beam_enable;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mono_count <= '0;
      interrupt_q <= 1'b0;
    end else if (mono_trigger) begin
      mono_count <= '0;
      interrupt_q <= 1'b1;
    end else if (interrupt_q && tick) begin
      if (mono_count == TIMER_W'(INTERRUPT_TICKS - 1)) begin
        interrupt_q <= 1'b0;
      end else begin
        mono_count <= mono_count + 1'b1;
      end
    end
  end

  // Relay outputs; one flop per coil, gathered so the struct has a single driver
  logic blower_q;
  logic heat_q;
  logic contactor_q;
  logic magnet_q_out;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      blower_q <= 1'b0;
      heat_q <= 1'b0;
      contactor_q <= 1'b0;
      magnet_q_out <= 1'b0;
    end else begin
      blower_q <= blower_latch;
      heat_q <= blower_latch;
      contactor_q <= filament_latch && air_q;
      magnet_q_out <= filament_latch && air_q;
    end
  end

  assign relays = {blower_q, heat_q, contactor_q, magnet_q_out, interrupt_q};

  // Fault lamp flasher
  logic [TIMER_W-1:0] flash_count;
  logic flash_phase;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flash_count <= '0;
      flash_phase <= 1'b0;
    end else if (!fault_stages[2]) begin
      flash_count <= '0;
      flash_phase <= 1'b0;
    end else if (tick) begin
      if (flash_count == TIMER_W'(FLASH_TICKS - 1)) begin
        flash_count <= '0;
        flash_phase <= !flash_phase;
      end else begin
        flash_count <= flash_count + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lamps <= '0;
    end else begin
      lamps.air_ok_lamp <= filament_latch && air_q;
      lamps.auto_on_lamp <= beam_latch;
      lamps.warmup_elapsed_lamp <= warmup_done;
      lamps.one_shot_trip_lamp <= fault_stages[1] && !fault_stages[2];
      lamps.fault_lamp <= fault_stages[2] && !flash_phase;
    end
  end

endmodule // transmitter_overload_sequencer

// ---- tos_pkg.sv ----
package tos_pkg;

  localparam int unsigned CLOCK_HZ = 50_000_000;

  // Delay figures in their own units
  localparam int unsigned RUNON_MIN = 5;
  localparam int unsigned WARMUP_MIN = 5;
  localparam int unsigned CLEAR_MIN = 1;
  localparam int unsigned INTERRUPT_MS = 1500;
  localparam int unsigned STUCK_MS = 500;

  // Derived tick counts: the divider makes a 1 ms tick
  localparam int unsigned TICK_HZ = 1000;
  localparam int unsigned TICK_DIV = CLOCK_HZ / TICK_HZ;
  localparam int unsigned MS_PER_MIN = 60_000;
  localparam int unsigned RUNON_TICKS = RUNON_MIN * MS_PER_MIN;
  localparam int unsigned WARMUP_TICKS = WARMUP_MIN * MS_PER_MIN;
  localparam int unsigned CLEAR_TICKS = CLEAR_MIN * MS_PER_MIN;
  localparam int unsigned INTERRUPT_TICKS = INTERRUPT_MS * TICK_HZ / 1000;
  localparam int unsigned STUCK_TICKS = STUCK_MS * TICK_HZ / 1000;

  localparam int unsigned TIMER_W = 20;
  localparam int unsigned OVL_COUNT = 5;
  localparam int unsigned FLASH_TICKS = 250;

  // Overload input positions
  localparam int unsigned OVL_CAVITY4 = 0;
  localparam int unsigned OVL_COLLECTOR = 1;
  localparam int unsigned OVL_BODY = 2;
  localparam int unsigned OVL_VSWR = 3;
  localparam int unsigned OVL_CAVITY3 = 4;

  typedef struct packed {
    logic filament_on_button;
    logic filament_off_button;
    logic beam_on_button;
    logic fault_clear_button;
    logic one_shot_trip_button;
    logic overload_memory_clear;
  } tos_buttons_type;

  typedef struct packed {
    logic blower_relay;
    logic heat_exchanger_relay;
    logic filament_contactor;
    logic magnet_supply_relay;
    logic beam_interrupt;
  } tos_relays_type;

  typedef struct packed {
    logic air_ok_lamp;
    logic auto_on_lamp;
    logic warmup_elapsed_lamp;
    logic one_shot_trip_lamp;
    logic fault_lamp;
  } tos_lamps_type;

  typedef enum logic [1:0] {
    tos_filament_off_button,
    tos_filament_on_button,
    tos_run_on
  } tos_fil_state_type;

endpackage

// ---- tos_properties.sv ----
`timescale 1ns/1ps

module tos_properties
  import tos_pkg::*;
#(
  parameter int unsigned OVL_N = OVL_COUNT,
  parameter int unsigned TICK_DIVIDE = TICK_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched inputs
  input wire tos_buttons_type buttons,
  input wire logic [OVL_N-1:0] overload_in,
  // Watched outputs
  input wire tos_relays_type relays,
  input wire logic beam_enable,
  input wire tos_lamps_type lamps,
  input wire logic [OVL_N-1:0] overload_memory,
  input wire logic [2:0] fault_stages
);
  // One tick of slack: the tick divider runs free of the trigger
  localparam int HOLD_MIN = (INTERRUPT_TICKS - 1) * TICK_DIVIDE;
  localparam int STUCK_LIM = (STUCK_TICKS + 2) * TICK_DIVIDE + 4;
  int hold_cnt;
  int stuck_cnt;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) hold_cnt <= 0;
    else hold_cnt <= relays.beam_interrupt ? hold_cnt + 1 : 0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) stuck_cnt <= 0;
    else stuck_cnt <= (overload_in != '0) ? stuck_cnt + 1 : 0;
  end

  filament_off_button_drop_a: assert property ($rose(buttons.filament_off_button) |-> ##3
    !relays.filament_contactor && !relays.magnet_supply_relay) else $error("contactor held");
  contactor_air_a: assert property (relays.filament_contactor |-> relays.blower_relay
    && relays.magnet_supply_relay && lamps.air_ok_lamp) else $error("contactor without air");
  cutoff_gate_a: assert property (fault_stages[2] |=> !beam_enable)
    else $error("beam on at lockout");
  stage_keep_a: assert property (fault_stages != 3'b000 |=> fault_stages == 3'b000
    || (fault_stages & $past(fault_stages)) == $past(fault_stages)) else $error("stage lost");
  one_shot_on_a: assert property ((fault_stages == 3'b011) [*2] |->
    lamps.one_shot_trip_lamp) else $error("one shot lamp dark");
  single_dark_a: assert property ((fault_stages == 3'b001) [*2] |->
    !lamps.one_shot_trip_lamp && !lamps.fault_lamp) else $error("lamp lit at one");
  lockout_lamp_a: assert property (fault_stages[2] [*2] |-> !lamps.one_shot_trip_lamp)
    else $error("one shot lamp at lockout");
  ovl_pulse_a: assert property ($changed(overload_memory) && overload_memory != '0 |->
    relays.beam_interrupt) else $error("overload without interrupt");
  beam_trig_a: assert property ($rose(beam_enable) |-> ##[0:2] relays.beam_interrupt)
    else $error("beam start without interrupt");
  hold_len_a: assert property ($fell(relays.beam_interrupt) |-> hold_cnt >= HOLD_MIN)
    else $error("interrupt too short");
  stuck_trip_a: assert property (stuck_cnt == STUCK_LIM |-> fault_stages[2])
    else $error("held overload not tripped");

  cover property ($rose(beam_enable));
  cover property ($rose(fault_stages[2]));
  cover property ($rose(lamps.warmup_elapsed_lamp));
endmodule // tos_properties

bind transmitter_overload_sequencer tos_properties #(.OVL_N(OVL_N), .TICK_DIVIDE(TICK_DIVIDE))
  u_props (.clock(clock), .rst(rst), .buttons(buttons), .overload_in(overload_in),
  .relays(relays), .beam_enable(beam_enable), .lamps(lamps),
  .overload_memory(overload_memory), .fault_stages(fault_stages));

// ---- tos_plant.sv ----
`timescale 1ns/1ps

module tos_plant
  import tos_pkg::*;
(
  // Clock
  input wire logic clock,
  // Relay coils
  input wire tos_relays_type relays,
  input wire logic air_hold,
  // Contacts
  output logic air_flow_normal,
  output logic filament_aux_closed,
  output logic magnet_current_relay
);
  // Air takes a few cycles to build after the blower starts
  logic [3:0] fan_q;

  initial begin
    fan_q = '0;
    air_flow_normal = 1'b0;
    filament_aux_closed = 1'b0;
    magnet_current_relay = 1'b0;
  end

  always @(posedge clock) begin
    fan_q <= {fan_q[2:0], relays.blower_relay};
    air_flow_normal <= fan_q[3] && !air_hold;
    filament_aux_closed <= relays.filament_contactor;
    magnet_current_relay <= relays.magnet_supply_relay;
  end
endmodule // tos_plant

// ---- tb.sv ----
`timescale 1ns/1ps

module tb;
  import tos_pkg::*;
  localparam int B_FON = 5;
  localparam int B_FOFF = 4;
  localparam int B_BEAM = 3;
  localparam int B_CLR = 2;
  localparam int B_ONE = 1;
  localparam int B_MEM = 0;
  logic clock = 1'b0;
  logic rst = 1'b1;
  tos_buttons_type buttons = '0;
  logic boards_present = 1'b1;
  logic interlocks_closed = 1'b1;
  logic air_hold = 1'b1;
  logic [4:0] overload_in = '0;
  logic air_flow_normal, filament_aux_closed, magnet_current_relay, beam_enable;
  tos_relays_type relays;
  tos_lamps_type lamps;
  logic [4:0] overload_memory;
  logic [2:0] fault_stages;
  logic saw_on, saw_off;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #10 clock = ~clock;

  transmitter_overload_sequencer #(.TICK_DIVIDE(5), .RUNON_COUNT(20), .WARMUP_COUNT(20),
    .CLEAR_COUNT(30)) u_dut (.clock(clock), .rst(rst), .buttons(buttons),
    .air_flow_normal(air_flow_normal), .boards_present(boards_present),
    .interlocks_closed(interlocks_closed), .filament_aux_closed(filament_aux_closed),
    .magnet_current_relay(magnet_current_relay), .overload_in(overload_in), .relays(relays),
    .beam_enable(beam_enable), .lamps(lamps), .overload_memory(overload_memory),
    .fault_stages(fault_stages));

  tos_plant u_plant (.clock(clock), .relays(relays), .air_hold(air_hold),
    .air_flow_normal(air_flow_normal), .filament_aux_closed(filament_aux_closed),
    .magnet_current_relay(magnet_current_relay));

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic press(input int b);
    @(negedge clock);
    buttons[b] = 1'b1;
    @(negedge clock);
    buttons[b] = 1'b0;
  endtask

  task automatic pulse(input int b);
    overload_in[b] = 1'b1;
    cyc(3);
    overload_in[b] = 1'b0;
  endtask

  task automatic chk(input string n, input logic [4:0] exp, input logic [4:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask

  task final_report;
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Whole run needs about 18300 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    cyc(6);
    rst = 1'b0;
    cyc(2);
    chk("stages", 5'h0, 5'(fault_stages));
    boards_present = 1'b0;
    press(B_FON);
    cyc(3);
    chk("relays", 5'h0, relays);
    boards_present = 1'b1;
    cyc(2);
    press(B_FON);
    cyc(3);
    chk("relays", 5'h18, relays);
    air_hold = 1'b0;
    cyc(10);
    chk("relays", 5'h1e, relays);
    chk("air lamp", 5'h1, 5'(lamps.air_ok_lamp));
    press(B_BEAM);
    cyc(3);
    chk("auto lamp", 5'h1, 5'(lamps.auto_on_lamp));
    chk("beam", 5'h0, 5'(beam_enable));
    chk("warm lamp", 5'h0, 5'(lamps.warmup_elapsed_lamp));
    cyc(100);
    chk("warm lamp", 5'h1, 5'(lamps.warmup_elapsed_lamp));
    chk("beam", 5'h1, 5'(beam_enable));
    chk("interrupt", 5'h1, 5'(relays.beam_interrupt));
    interlocks_closed = 1'b0;
    cyc(3);
    chk("beam", 5'h0, 5'(beam_enable));
    interlocks_closed = 1'b1;
    cyc(3);
    chk("beam", 5'h1, 5'(beam_enable));
    cyc(7600);
    chk("interrupt", 5'h0, 5'(relays.beam_interrupt));
    pulse(OVL_VSWR);
    chk("memory", 5'h08, overload_memory);
    chk("stages", 5'h1, 5'(fault_stages));
    chk("interrupt", 5'h1, 5'(relays.beam_interrupt));
    chk("trip lamps", 5'h0, 5'(lamps[1:0]));
    cyc(2);
    chk("beam", 5'h1, 5'(beam_enable));
    cyc(200);
    chk("stages", 5'h0, 5'(fault_stages));
    pulse(OVL_CAVITY4);
    cyc(5);
    pulse(OVL_COLLECTOR);
    chk("stages", 5'h3, 5'(fault_stages));
    cyc(1);
    chk("one shot", 5'h1, 5'(lamps.one_shot_trip_lamp));
    cyc(5);
    pulse(OVL_CAVITY3);
    chk("stages", 5'h7, 5'(fault_stages));
    cyc(2);
    chk("beam", 5'h0, 5'(beam_enable));
    chk("one shot", 5'h0, 5'(lamps.one_shot_trip_lamp));
    saw_on = 1'b0;
    saw_off = 1'b0;
    repeat (7600) begin
      cyc(1);
      saw_on = saw_on | lamps.fault_lamp;
      saw_off = saw_off | !lamps.fault_lamp;
    end
    chk("flash", 5'h1, 5'(saw_on & saw_off));
    chk("stages", 5'h7, 5'(fault_stages));
    chk("beam", 5'h0, 5'(beam_enable));
    chk("memory", 5'h1b, overload_memory);
    press(B_MEM);
    cyc(3);
    chk("memory", 5'h0, overload_memory);
    press(B_CLR);
    cyc(3);
    chk("stages", 5'h0, 5'(fault_stages));
    cyc(2);
    chk("beam", 5'h1, 5'(beam_enable));
    press(B_ONE);
    cyc(3);
    chk("one shot", 5'h1, 5'(lamps.one_shot_trip_lamp));
    pulse(OVL_BODY);
    chk("stage three", 5'h1, 5'(fault_stages[2]));
    press(B_CLR);
    cyc(3);
    overload_in[OVL_CAVITY4] = 1'b1;
    cyc(2600);
    chk("stage three", 5'h1, 5'(fault_stages[2]));
    chk("beam", 5'h0, 5'(beam_enable));
    press(B_CLR);
    cyc(3);
    chk("stage three", 5'h1, 5'(fault_stages[2]));
    overload_in = '0;
    press(B_CLR);
    cyc(3);
    press(B_FOFF);
    cyc(3);
    chk("contactor", 5'h0, 5'(relays[2:1]));
    cyc(80);
    chk("blower", 5'h3, 5'(relays[4:3]));
    cyc(40);
    chk("blower", 5'h0, 5'(relays[4:3]));
    final_report();
  end
endmodule // tb
